// ### rtl/nid_device.sv
/*
  Instruction decoder for a dual-bank non-volatile memory.
  Assumes the bus is driven by logic on clk_i; array and algorithms are outside.
*/
`timescale 1ns/1ps
`default_nettype none
module nid_device #(
  parameter logic [7:0] FLASH_ID  = 8'h5a, // Arbitrary identifier value
  parameter int         PU_CYCLES = nid_pkg::PU_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  nid_bus_if.dev           bus,
  input  wire logic [7:0]  mem_rdata_i,
  input  wire logic [7:0]  prot_i,
  input  wire logic        algorithm_error_flag_i,
  output logic             prog_o,
  output logic             erase_sect_o,
  output logic [7:0]       erase_mask_o,
  output logic             erase_bank_o,
  output logic             suspend_o,
  output logic             resume_o,
  output logic             ee_wr_o,
  output logic             otp_wr_o,
  output logic [15:0]      op_addr_o,
  output logic [7:0]       op_data_o,
  output logic [15:0]      rd_addr_o,
  output logic             otp_rd_o,
  output logic             id_mode_o,
  output logic             ee_pd_o,
  output logic             software_write_protect_o,
  output logic             ee_ready_o,
  output logic             flash_error_o
);
  localparam int PU_W_L = nid_pkg::PU_W;
  localparam logic [PU_W_L-1:0] PU_END = PU_W_L'(PU_CYCLES);

  nid_pkg::nid_state_t state_reg, state_next;
  logic [11:0]   tmr_reg;
  logic [PU_W_L-1:0] pu_cnt_reg;
  logic          pu_done_reg;
  logic          ee_seq_reg, ee_seq_next;
  logic          id_reg, otp_reg, pd_reg, sdp_reg;
  logic [7:0]    mask_reg;
  logic          rd_pend_reg, rd_ee_reg, rd_fl_reg;
  logic [2:0]    rd_sel_reg;
  logic [7:0]    rdata_reg;
  logic          ev_prog, ev_bank, ev_susp, ev_res, ev_eewr, ev_otpw;
  logic          ev_sdp_on, ev_sdp_off, ev_pd, ev_ret, ev_id, ev_otp;
  logic          ev_frst, ev_sadd, ev_sgo, bad;

  wire fl_acc = (|bus.fsel) & ~(|bus.esel);
  wire ee_acc = (|bus.esel) & ~(|bus.fsel);
  wire wr     = bus.wr_stb & (fl_acc | ee_acc);
  wire [11:0] a_lo = bus.addr[11:0];
  wire [7:0]  d    = bus.wdata;
  wire at1 = (a_lo == nid_pkg::ADDR_UNL1);
  wire at2 = (a_lo == nid_pkg::ADDR_UNL2);
  wire same_bank = (ee_acc == ee_seq_reg);
  wire tmo = (state_reg != nid_pkg::ST_IDLE) && (tmr_reg == 12'h000);

  always_comb
  begin
    state_next = state_reg;
    ee_seq_next = ee_seq_reg;
    {ev_prog, ev_bank, ev_susp, ev_res, ev_eewr, ev_otpw} = 6'h00;
    {ev_sdp_on, ev_sdp_off, ev_pd, ev_ret, ev_id, ev_otp} = 6'h00;
    {ev_frst, ev_sadd, ev_sgo, bad} = 4'h0;
    if (tmo)
    begin
      state_next = nid_pkg::ST_IDLE;
      ev_sgo = (state_reg == nid_pkg::ST_SECQ);
    end
    else if (wr)
    begin
      unique case (state_reg)
        nid_pkg::ST_IDLE:
        begin
          ee_seq_next = ee_acc;
          if (d == nid_pkg::CMD_UNLOCK1 && at1)
            state_next = nid_pkg::ST_UNL1;
          else if (fl_acc && d == nid_pkg::CMD_RESET)
            ev_frst = 1'b1;
          else if (fl_acc && d == nid_pkg::CMD_SUSP)
            ev_susp = 1'b1;
          else if (fl_acc && d == nid_pkg::CMD_SECT)
            ev_res = 1'b1;
          // return from OTP read or power-down
          else if (ee_acc && d == nid_pkg::CMD_RESET)
            ev_ret = 1'b1;
          else
            bad = 1'b1;
        end
        nid_pkg::ST_UNL1:
        begin
          if (same_bank && d == nid_pkg::CMD_UNLOCK2 && at2)
            state_next = nid_pkg::ST_UNL2;
          else
            bad = 1'b1;
        end
        nid_pkg::ST_UNL2:
        begin
          state_next = nid_pkg::ST_IDLE;
          if (same_bank && fl_acc && d == nid_pkg::CMD_RESET)
            ev_frst = 1'b1;
          else if (!same_bank || !at1)
            bad = 1'b1;
          else if (d == nid_pkg::CMD_AUTOSEL)
          begin
            ev_id = fl_acc;
            ev_otp = ee_acc;
          end
          else if (d == nid_pkg::CMD_PROG)
          begin
            ev_sdp_on = ee_acc;
            state_next = ee_acc ? nid_pkg::ST_EEWR : nid_pkg::ST_PROG;
          end
          else if (d == nid_pkg::CMD_ERASE)
            state_next = nid_pkg::ST_ERS0;
          else if (ee_acc && d == nid_pkg::CMD_SECT)
            ev_pd = 1'b1;
          else if (ee_acc && d == nid_pkg::CMD_SUSP && !sdp_reg)
            state_next = nid_pkg::ST_OTPW;
          else
            bad = 1'b1;
        end
        nid_pkg::ST_ERS0:
        begin
          if (same_bank && d == nid_pkg::CMD_UNLOCK1 && at1)
            state_next = nid_pkg::ST_ERS1;
          else
            bad = 1'b1;
        end
        nid_pkg::ST_ERS1:
        begin
          if (same_bank && d == nid_pkg::CMD_UNLOCK2 && at2)
            state_next = nid_pkg::ST_ERS2;
          else
            bad = 1'b1;
        end
        nid_pkg::ST_ERS2:
        begin
          state_next = nid_pkg::ST_IDLE;
          if (same_bank && fl_acc && d == nid_pkg::CMD_SECT)
          begin
            ev_sadd = 1'b1;
            state_next = nid_pkg::ST_SECQ;
          end
          else if (same_bank && fl_acc && at1 && d == nid_pkg::CMD_BANK)
            ev_bank = 1'b1;
          else if (same_bank && ee_acc && at1 && d == nid_pkg::CMD_SDP_OFF)
            ev_sdp_off = 1'b1;
          else
            bad = 1'b1;
        end
        nid_pkg::ST_PROG:
        begin
          state_next = nid_pkg::ST_IDLE;
          ev_prog = fl_acc;
          bad = ee_acc;
        end
        nid_pkg::ST_SECQ:
        begin
          if (fl_acc && d == nid_pkg::CMD_SECT)
            ev_sadd = 1'b1;
          else
          begin
            bad = 1'b1;
            state_next = nid_pkg::ST_IDLE;
          end
        end
        nid_pkg::ST_EEWR, nid_pkg::ST_OTPW:
        begin
          ev_eewr = ee_acc && state_reg == nid_pkg::ST_EEWR;
          ev_otpw = ee_acc && state_reg == nid_pkg::ST_OTPW;
          if (fl_acc)
          begin
            bad = 1'b1;
            state_next = nid_pkg::ST_IDLE;
          end
        end
      endcase
      if (bad)
      begin
        state_next = nid_pkg::ST_IDLE;
        ev_eewr = ee_acc && !sdp_reg;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= nid_pkg::ST_IDLE;
      ee_seq_reg <= 1'b0;
      tmr_reg <= 12'h000;
    end
    else
    begin
      state_reg <= state_next;
      ee_seq_reg <= ee_seq_next;
      tmr_reg <= wr ? nid_pkg::TO_CYC : (tmo ? tmr_reg : tmr_reg - 12'h001);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pu_cnt_reg <= '0;
      pu_done_reg <= 1'b0;
    end
    else if (!pu_done_reg)
    begin
      pu_cnt_reg <= pu_cnt_reg + 1'b1;
      pu_done_reg <= (pu_cnt_reg == PU_END - 1'b1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      {id_reg, otp_reg, pd_reg, sdp_reg} <= 4'h0;
      mask_reg <= 8'h00;
    end
    else
    begin
      id_reg <= (id_reg & ~ev_frst) | ev_id;
      // return clears OTP read and power-down
      otp_reg <= (otp_reg & ~ev_ret) | ev_otp;
      pd_reg <= (pd_reg & ~ev_ret) | ev_pd;
      sdp_reg <= (sdp_reg & ~ev_sdp_off) | ev_sdp_on;
      mask_reg <= ev_sgo ? 8'h00 : (ev_sadd ? (mask_reg | bus.fsel) : mask_reg);
    end
  end

  wire ee_ok = pu_done_reg & ~pd_reg;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      {prog_o, erase_sect_o, erase_bank_o, suspend_o, resume_o} <= 5'h00;
      {ee_wr_o, otp_wr_o} <= 2'h0;
      erase_mask_o <= 8'h00;
      op_addr_o <= 16'h0000;
      op_data_o <= 8'h00;
    end
    else
    begin
      prog_o <= ev_prog;
      erase_sect_o <= ev_sgo;
      erase_bank_o <= ev_bank;
      suspend_o <= ev_susp;
      resume_o <= ev_res;
      ee_wr_o <= ev_eewr & ee_ok;
      otp_wr_o <= ev_otpw & ee_ok;
      if (ev_sgo)
        erase_mask_o <= mask_reg;
      if (wr)
      begin
        op_addr_o <= bus.addr;
        op_data_o <= d;
      end
    end
  end

  // Read path, two stages
  wire [2:0] idsel = {bus.addr[6], bus.addr[1], bus.addr[0]};
  wire [7:0] prot_byte = {7'h00, |(prot_i & bus.fsel)};
  logic [7:0] prot_reg;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      {rd_pend_reg, rd_ee_reg, rd_fl_reg} <= 3'h0;
      rd_sel_reg <= 3'h0;
      rd_addr_o <= 16'h0000;
      prot_reg <= 8'h00;
      rdata_reg <= 8'h00;
    end
    else
    begin
      rd_pend_reg <= bus.rd_stb;
      if (bus.rd_stb)
      begin
        rd_ee_reg <= ee_acc;
        rd_fl_reg <= fl_acc;
        rd_sel_reg <= idsel;
        rd_addr_o <= bus.addr;
        prot_reg <= prot_byte;
      end
      if (rd_pend_reg)
      begin
        if (rd_fl_reg && id_reg && rd_sel_reg == nid_pkg::IDSEL_ID)
          rdata_reg <= FLASH_ID;
        else if (rd_fl_reg && id_reg && rd_sel_reg == nid_pkg::IDSEL_PROT)
          rdata_reg <= prot_reg;
        else if (rd_ee_reg && pd_reg)
          rdata_reg <= 8'h00;
        // OTP bytes come from the array side
        else
          rdata_reg <= mem_rdata_i;
      end
    end
  end

  assign bus.rdata = rdata_reg;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      {otp_rd_o, id_mode_o, ee_pd_o, software_write_protect_o} <= 4'h0;
      ee_ready_o <= 1'b0;
      flash_error_o <= 1'b0;
    end
    else
    begin
      otp_rd_o <= otp_reg;
      id_mode_o <= id_reg;
      ee_pd_o <= pd_reg;
      software_write_protect_o <= sdp_reg;
      ee_ready_o <= ee_ok;
      flash_error_o <= algorithm_error_flag_i;
    end
  end
endmodule
`default_nettype wire

// ### rtl/nid_pkg.sv
/*
  Shared constants and types for the instruction decoder and its host end.
  Assumes a single 50 MHz clock shared by both ends.
*/
package nid_pkg;
  // Instruction bytes
  localparam logic [7:0]  CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0]  CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0]  CMD_AUTOSEL = 8'h90;
  localparam logic [7:0]  CMD_PROG    = 8'ha0;
  localparam logic [7:0]  CMD_ERASE   = 8'h80;
  localparam logic [7:0]  CMD_SECT    = 8'h30;
  localparam logic [7:0]  CMD_BANK    = 8'h10;
  localparam logic [7:0]  CMD_SUSP    = 8'hb0;
  localparam logic [7:0]  CMD_SDP_OFF = 8'h20;
  localparam logic [7:0]  CMD_RESET   = 8'hf0;
  // Command addresses, low twelve bits only
  localparam logic [11:0] ADDR_UNL1   = 12'h555;
  localparam logic [11:0] ADDR_UNL2   = 12'haaa;
  // Identifier read select on {A6,A1,A0}
  localparam logic [2:0]  IDSEL_ID    = 3'h1;
  localparam logic [2:0]  IDSEL_PROT  = 3'h2;
  // Timing
  localparam int          CLK_MHZ     = 50;
  localparam int          WIN_NS      = 80000;
  localparam int          WIN_CYC     = (WIN_NS * CLK_MHZ) / 1000;
  localparam logic [11:0] TO_CYC      = 12'(WIN_CYC);
  localparam int          PU_MS       = 5;
  localparam int          PU_CYC      = PU_MS * CLK_MHZ * 1000;
  localparam int          PU_W        = 18;
  // Host register map (byte addresses)
  localparam logic [7:0]  REG_ADDR    = 8'h00;
  localparam logic [7:0]  REG_SEL     = 8'h04;
  localparam logic [7:0]  REG_DATA    = 8'h08;
  localparam logic [7:0]  REG_CTRL    = 8'h0c;
  localparam logic [7:0]  REG_STAT    = 8'h10;
  localparam int          CTRL_WR     = 0;
  localparam int          CTRL_RD     = 1;
  localparam int          CTRL_UNL    = 2;
  localparam int          STAT_BUSY   = 0;
  localparam int          STAT_BADSEL = 1;
  localparam int          STAT_RD_LSB = 8;

  typedef enum logic [3:0] {
    ST_IDLE, ST_UNL1, ST_UNL2, ST_ERS0, ST_ERS1, ST_ERS2,
    ST_PROG, ST_SECQ, ST_EEWR, ST_OTPW
  } nid_state_t;

  typedef enum logic [2:0] {
    HS_IDLE, HS_U2, HS_OP, HS_RW1, HS_RW2, HS_RW3
  } nid_hstate_t;
endpackage

// ### rtl/nid_bus_if.sv
/*
  Parallel address/data bus between host end and decoder end.
  Assumes both ends run on the same clock; strobes are one-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none
interface nid_bus_if;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        wr_stb;
  logic        rd_stb;
  logic [7:0]  fsel;
  logic [3:0]  esel;

  modport dev  (input addr, wdata, wr_stb, rd_stb, fsel, esel, output rdata);
  modport host (output addr, wdata, wr_stb, rd_stb, fsel, esel, input rdata);
endinterface
`default_nettype wire

// ### rtl/nid_host.sv
/*
  Host end: APB slave registers that issue bus cycles to the decoder, optionally after the two unlock cycles.
  Assumes software composes instruction sequences and runs from other memory.
*/
`timescale 1ns/1ps
`default_nettype none
module nid_host (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  nid_bus_if.host          bus
);
  nid_pkg::nid_hstate_t hs_reg;
  logic [15:0] addr_reg;
  logic [11:0] sel_reg;
  logic [7:0]  data_reg, rdata_reg;
  logic [2:0]  ctrl_reg;
  logic        badsel_reg;
  logic [15:0] baddr_reg;
  logic [7:0]  bdata_reg;
  logic        bwr_reg, brd_reg;

  wire acc    = psel & penable & ~pready;
  wire take   = psel & penable & pready & pwrite;
  wire busy   = (hs_reg != nid_pkg::HS_IDLE);
  wire a_addr = (paddr == nid_pkg::REG_ADDR);
  wire a_sel  = (paddr == nid_pkg::REG_SEL);
  wire a_data = (paddr == nid_pkg::REG_DATA);
  wire a_ctrl = (paddr == nid_pkg::REG_CTRL);
  wire a_stat = (paddr == nid_pkg::REG_STAT);
  wire mapped = a_addr | a_sel | a_data | a_ctrl | a_stat;
  wire go     = take & a_ctrl & ~busy & (pwdata[nid_pkg::CTRL_WR] | pwdata[nid_pkg::CTRL_RD]);
  wire sel_ok = (|sel_reg[7:0]) ^ (|sel_reg[11:8]);

  wire [31:0] stat_w = {16'h0000, rdata_reg, 6'h00, badsel_reg, busy};
  wire [31:0] rd_w = a_addr ? {16'h0000, addr_reg} :
                     a_sel  ? {20'h00000, sel_reg} :
                     a_data ? {24'h000000, data_reg} :
                     a_ctrl ? {29'h00000000, ctrl_reg} :
                     a_stat ? stat_w : 32'h00000000;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= acc;
      pslverr <= acc & ~mapped;
      prdata <= acc ? rd_w : prdata;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      addr_reg <= 16'h0000;
      sel_reg <= 12'h000;
      data_reg <= 8'h00;
      ctrl_reg <= 3'h0;
    end
    else if (take && !busy)
    begin
      if (a_addr)
        addr_reg <= pwdata[15:0];
      if (a_sel)
        sel_reg <= pwdata[11:0];
      if (a_data)
        data_reg <= pwdata[7:0];
      if (a_ctrl)
        ctrl_reg <= pwdata[2:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      hs_reg <= nid_pkg::HS_IDLE;
      {bwr_reg, brd_reg, badsel_reg} <= 3'h0;
      baddr_reg <= 16'h0000;
      bdata_reg <= 8'h00;
      rdata_reg <= 8'h00;
    end
    else
    begin
      bwr_reg <= 1'b0;
      brd_reg <= 1'b0;
      unique case (hs_reg)
        nid_pkg::HS_IDLE:
        begin
          if (go)
          begin
            badsel_reg <= ~sel_ok;
            if (sel_ok && pwdata[nid_pkg::CTRL_UNL])
            begin
              baddr_reg <= {addr_reg[15:12], nid_pkg::ADDR_UNL1};
              bdata_reg <= nid_pkg::CMD_UNLOCK1;
              bwr_reg <= 1'b1;
              hs_reg <= nid_pkg::HS_U2;
            end
            else if (sel_ok)
              hs_reg <= nid_pkg::HS_OP;
          end
        end
        nid_pkg::HS_U2:
        begin
          baddr_reg <= {addr_reg[15:12], nid_pkg::ADDR_UNL2};
          bdata_reg <= nid_pkg::CMD_UNLOCK2;
          bwr_reg <= 1'b1;
          hs_reg <= nid_pkg::HS_OP;
        end
        nid_pkg::HS_OP:
        begin
          baddr_reg <= addr_reg;
          bdata_reg <= data_reg;
          bwr_reg <= ctrl_reg[nid_pkg::CTRL_WR];
          brd_reg <= ~ctrl_reg[nid_pkg::CTRL_WR];
          hs_reg <= ctrl_reg[nid_pkg::CTRL_WR] ? nid_pkg::HS_IDLE : nid_pkg::HS_RW1;
        end
        nid_pkg::HS_RW1:
          hs_reg <= nid_pkg::HS_RW2;
        nid_pkg::HS_RW2:
          hs_reg <= nid_pkg::HS_RW3;
        nid_pkg::HS_RW3:
        begin
          rdata_reg <= bus.rdata;
          hs_reg <= nid_pkg::HS_IDLE;
        end
      endcase
    end
  end

  assign bus.addr = baddr_reg;
  assign bus.wdata = bdata_reg;
  assign bus.wr_stb = bwr_reg;
  assign bus.rd_stb = brd_reg;
  assign bus.fsel = sel_reg[7:0];
  assign bus.esel = sel_reg[11:8];
endmodule
`default_nettype wire

// ### sim/nid_chk_sva.sv
/*
  Checker on the bus between host and decoder ends, plus decoder pulses.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module nid_chk (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [7:0]  fsel,
  input wire logic [3:0]  esel,
  input wire logic        prog_o,
  input wire logic [15:0] op_addr_o,
  input wire logic [7:0]  op_data_o,
  input wire logic        suspend_o,
  input wire logic        erase_bank_o,
  input wire logic        ee_wr_o,
  input wire logic        ee_ready_o,
  input wire logic        ee_pd_o,
  input wire logic        id_mode_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  strb_excl_a: assert property (!(wr_stb && rd_stb))
    else $error("read and write strobes together");
  prog_cause_a: assert property (prog_o |-> $past(wr_stb) && op_data_o == $past(wdata)
    && op_addr_o == $past(addr)) else $error("program pulse without its write");
  prog_sel_a: assert property (prog_o |-> $past(fsel) != 8'h00
    && $past(esel) == 4'h0) else $error("program pulse with wrong selects");
  ee_lock_a: assert property (ee_wr_o |-> ee_ready_o && $past(esel) != 4'h0)
    else $error("eeprom write during lockout");
  susp_byte_a: assert property (suspend_o |-> $past(wr_stb)
    && $past(wdata) == 8'hb0) else $error("suspend without its byte");
  bank_cause_a: assert property (erase_bank_o |-> $past(wdata) == 8'h10
    && ($past(addr) & 16'h0fff) == 16'h0555) else $error("bank erase cause");
  start_read_a: assert property ($rose(rst_n_i) |-> !id_mode_o
    && !ee_pd_o && !ee_ready_o) else $error("not in read mode after reset");
  pd_cause_a: assert property ($rose(ee_pd_o) |-> $past(wdata, 2) == 8'h30
    && $past(esel, 2) != 4'h0) else $error("power-down cause");
  id_cause_a: assert property ($rose(id_mode_o) |-> $past(wdata, 2) == 8'h90
    && $past(fsel, 2) != 8'h00) else $error("identifier mode cause");
endmodule
`default_nettype wire

// ### sim/testbench.sv
/*
  Bench driving the host end over APB against the decoder end.
  Assumes design package, interface and both ends compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [11:0] FS = 12'h001;
  localparam logic [11:0] ES = 12'h100;
  localparam logic [2:0]  W  = 3'h1;
  localparam logic [2:0]  R  = 3'h2;
  localparam logic [2:0]  UW = 3'h5;
  localparam logic [7:0]  ID = 8'h3c; // Arbitrary identifier value
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err;
  logic [7:0]  mem_rdata_i = 8'hc3;
  logic [7:0]  prot_i = 8'h01;
  logic        algorithm_error_flag_i = 1'b0;
  logic        prog_o, erase_sect_o, erase_bank_o, suspend_o, resume_o, ee_wr_o;
  logic        otp_wr_o, otp_rd_o, id_mode_o, ee_pd_o, software_write_protect_o;
  logic        ee_ready_o, flash_error_o;
  logic [7:0]  erase_mask_o, op_data_o;
  logic [15:0] op_addr_o, rd_addr_o;
  logic [6:0]  pul;
  int          pc [7];
  int          b [7];
  int          n_fail = 0;
  int          total_checks = 0;
  int          cyc = 0;

  nid_bus_if bus ();
  nid_host nid_host_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus(bus));
  nid_device #(.FLASH_ID(ID), .PU_CYCLES(200)) nid_device_i (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .bus(bus), .mem_rdata_i(mem_rdata_i), .prot_i(prot_i),
    .algorithm_error_flag_i(algorithm_error_flag_i), .prog_o(prog_o),
    .erase_sect_o(erase_sect_o), .erase_mask_o(erase_mask_o), .erase_bank_o(erase_bank_o),
    .suspend_o(suspend_o), .resume_o(resume_o), .ee_wr_o(ee_wr_o), .otp_wr_o(otp_wr_o),
    .op_addr_o(op_addr_o), .op_data_o(op_data_o), .rd_addr_o(rd_addr_o),
    .otp_rd_o(otp_rd_o), .id_mode_o(id_mode_o), .ee_pd_o(ee_pd_o),
    .software_write_protect_o(software_write_protect_o), .ee_ready_o(ee_ready_o),
    .flash_error_o(flash_error_o));
  nid_chk nid_chk_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr(bus.addr), .wdata(bus.wdata),
    .wr_stb(bus.wr_stb), .rd_stb(bus.rd_stb), .fsel(bus.fsel), .esel(bus.esel),
    .prog_o(prog_o), .op_addr_o(op_addr_o), .op_data_o(op_data_o), .suspend_o(suspend_o),
    .erase_bank_o(erase_bank_o), .ee_wr_o(ee_wr_o), .ee_ready_o(ee_ready_o),
    .ee_pd_o(ee_pd_o), .id_mode_o(id_mode_o));

  assign pul = {otp_wr_o, ee_wr_o, resume_o, suspend_o, erase_bank_o, erase_sect_o, prog_o};
  always #10 clk_i = ~clk_i;

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    for (int i = 0; i < 7; i++)
      if (pul[i] === 1'b1)
        pc[i] <= pc[i] + 1;
    if (cyc == 40000)
    begin
      n_fail++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmd(input logic [11:0] s, input logic [15:0] a, input logic [7:0] d,
                     input logic [2:0] c);
    apb(1'b1, nid_pkg::REG_SEL, {20'h0, s});
    apb(1'b1, nid_pkg::REG_ADDR, {16'h0, a});
    apb(1'b1, nid_pkg::REG_DATA, {24'h0, d});
    apb(1'b1, nid_pkg::REG_CTRL, {29'h0, c});
    do apb(1'b0, nid_pkg::REG_STAT, 32'h0); while (rd[0] !== 1'b0);
    repeat (3) @(posedge clk_i);
  endtask

  task automatic t_lock();
    b = pc;
    chk("ready", 32'(ee_ready_o), 32'h0);
    cmd(ES, 16'h0040, 8'h11, W);
    chk("ee_early", pc[5] - b[5], 32'h0);
    repeat (250) @(posedge clk_i);
    chk("ready", 32'(ee_ready_o), 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'(err), 32'h1);
  endtask

  task automatic t_id();
    cmd(FS, 16'h0555, 8'h90, UW);
    cmd(FS, 16'h0001, 8'h00, R);
    chk("ident", 32'(rd[15:8]), 32'(ID));
    cmd(FS, 16'h0002, 8'h00, R);
    chk("protect", 32'(rd[15:8]), 32'h1);
    chk("rd_addr", 32'(rd_addr_o), 32'h0002);
    cmd(12'h002, 16'h0002, 8'h00, R);
    chk("unprot", 32'(rd[15:8]), 32'h0);
    algorithm_error_flag_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("err_flag", 32'(flash_error_o), 32'h1);
    algorithm_error_flag_i <= 1'b0;
    cmd(FS, 16'h0000, 8'hf0, W);
    chk("id_off", 32'(id_mode_o), 32'h0);
    cmd(FS, 16'h0555, 8'h90, UW);
    cmd(FS, 16'h0000, 8'hf0, UW);
    chk("id_off2", 32'(id_mode_o), 32'h0);
  endtask

  task automatic t_prog();
    b = pc;
    cmd(FS, 16'hf555, 8'ha0, UW);
    cmd(FS, 16'h1234, 8'h5a, W);
    chk("prog", pc[0] - b[0], 32'h1);
    chk("op_addr", 32'(op_addr_o), 32'h1234);
    chk("op_data", 32'(op_data_o), 32'h5a);
    cmd(FS, 16'h0555, 8'h77, UW);
    cmd(FS, 16'h0555, 8'ha0, W);
    cmd(FS, 16'h1234, 8'h5a, W);
    chk("bad_seq", pc[0] - b[0], 32'h1);
    cmd(12'h101, 16'h0555, 8'ha0, UW);
    chk("badsel", 32'(rd[1]), 32'h1);
  endtask

  task automatic t_erase();
    b = pc;
    cmd(FS, 16'h0555, 8'h80, UW);
    repeat (4100) @(posedge clk_i);
    cmd(FS, 16'h0555, 8'h10, UW);
    chk("late_bank", pc[2] - b[2], 32'h0);
    cmd(12'h008, 16'h0555, 8'h80, UW);
    cmd(12'h008, 16'h0c10, 8'h30, UW);
    cmd(12'h020, 16'h1400, 8'h30, W);
    repeat (4200) @(posedge clk_i);
    chk("sect", pc[1] - b[1], 32'h1);
    chk("mask", 32'(erase_mask_o), 32'h28);
    chk("no_res", pc[4] - b[4], 32'h0);
    cmd(FS, 16'h0555, 8'h80, UW);
    cmd(FS, 16'h0555, 8'h10, UW);
    chk("bank", pc[2] - b[2], 32'h1);
    cmd(FS, 16'h3333, 8'hb0, W);
    cmd(FS, 16'h3333, 8'h30, W);
    chk("susp", pc[3] - b[3], 32'h1);
    chk("res", pc[4] - b[4], 32'h1);
  endtask

  task automatic t_ee();
    b = pc;
    cmd(ES, 16'h0555, 8'h30, UW);
    chk("pd", 32'(ee_pd_o), 32'h1);
    cmd(ES, 16'h0000, 8'hf0, W);
    chk("pd_off", 32'(ee_pd_o), 32'h0);
    cmd(ES, 16'h0555, 8'ha0, UW);
    cmd(ES, 16'h0041, 8'h34, W);
    chk("sdp_on", 32'(software_write_protect_o), 32'h1);
    chk("ee_wr", pc[5] - b[5], 32'h1);
    repeat (4100) @(posedge clk_i);
    cmd(ES, 16'h0555, 8'hb0, UW);
    cmd(ES, 16'h0002, 8'h56, W);
    chk("otp_lock", pc[6] - b[6], 32'h0);
    cmd(ES, 16'h0555, 8'h80, UW);
    cmd(ES, 16'h0555, 8'h20, UW);
    chk("sdp_off", 32'(software_write_protect_o), 32'h0);
    cmd(ES, 16'h0555, 8'hb0, UW);
    cmd(ES, 16'h0002, 8'h56, W);
    chk("otp_wr", pc[6] - b[6], 32'h1);
    repeat (4100) @(posedge clk_i);
    cmd(ES, 16'h0555, 8'h90, UW);
    chk("otp_mode", 32'(otp_rd_o), 32'h1);
    cmd(ES, 16'h0003, 8'h00, R);
    chk("otp_rd", 32'(rd[15:8]), 32'hc3);
    cmd(ES, 16'h0000, 8'hf0, W);
    chk("otp_off", 32'(otp_rd_o), 32'h0);
  endtask

  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_lock();
    t_id();
    t_prog();
    t_erase();
    t_ee();
    close_out();
  end
endmodule
`default_nettype wire
